// [logic/slave_port_regs_pkg.sv]
// Constants for the slave port configuration and error logging registers.
package slave_port_regs_pkg;

    // ------------------------------------------------------------------
    // Register indices on the device control register port
    // ------------------------------------------------------------------
    localparam logic [9:0] IDX_PORT_CONFIG        = 10'h044;
    localparam logic [9:0] IDX_FAIL_ADDR_UPPER    = 10'h046;
    localparam logic [9:0] IDX_FAIL_ADDR_LOWER    = 10'h047;
    localparam logic [9:0] IDX_FAIL_QUALIFIERS    = 10'h048;
    localparam logic [9:0] IDX_MISC_STATUS        = 10'h049;
    localparam logic [9:0] IDX_MASTER_IRQ_STATUS  = 10'h04a;
    localparam logic [9:0] IDX_STATE_MACHINE_VIEW = 10'h04b;
    localparam logic [9:0] IDX_MISC_CONTROL       = 10'h04c;

    // ------------------------------------------------------------------
    // Reset values (bit 0 is the most significant bit)
    // ------------------------------------------------------------------
    localparam logic [0:31] PORT_CONFIG_RESET = 32'h8033_336c;
    localparam logic [0:31] ZERO_WORD         = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Port configuration field positions
    // ------------------------------------------------------------------
    localparam int CFG_CAPTURE_HOLD_LOCK = 0;
    localparam int CFG_WR_MEMCTL_THR_LSB = 19;
    localparam int CFG_WR_MASTER_THR_LSB = 23;
    localparam int CFG_LOCKED_XFER       = 25;
    localparam int CFG_READ_PIPE         = 26;
    localparam int CFG_WRITE_PIPE        = 27;
    localparam int CFG_WRITE_POST        = 28;
    localparam int CFG_MISMATCH_LOG      = 30;
    localparam int CFG_SIZE_CHECK_OFF    = 31;

    // ------------------------------------------------------------------
    // Status and control field positions
    // ------------------------------------------------------------------
    localparam int ST_POSTING_CFG_ERR = 0;
    localparam int ST_ILLEGAL_CMD     = 1;
    localparam int ST_ADDR_MISMATCH   = 2;
    localparam int ST_QUEUE_FIRST     = 18;
    localparam int QUEUE_FLAG_COUNT   = 14;
    localparam int MASTER_INTERRUPT_REQUEST_FIRST         = 28;
    localparam int MASTER_COUNT       = 4;
    localparam int QRESET_FIRST       = 25;
    localparam int QRESET_COUNT       = 7;
    localparam int CTL_WIDE_PORT      = 0;

    // ------------------------------------------------------------------
    // Legal size codes
    // ------------------------------------------------------------------
    localparam logic [3:0] SIZE_SINGLE    = 4'h0;
    localparam logic [3:0] SIZE_LINE_LAST = 4'h3;
    localparam logic [3:0] SIZE_BURST_LO  = 4'ha;
    localparam logic [3:0] SIZE_BURST_HI  = 4'hc;

endpackage

// [logic/slave_port_cfg_error_logging.sv]
// Configuration, error capture and status registers of the second slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Write bursts to memory controller split per 3-bit threshold, reset 011.
// - Write bursts to master port split per 3-bit threshold; software avoids 101-111.
// - Locked transfers allowed only while lock-transfer bit is 1, reset 1.
// - Read addresses pipelined while read-pipelining bit is 1, reset 1.
// - Write pipelining resets 0 and is forced 0 while posting is off.
// - Posting off accepts singles only; others raise interrupt flag 11.
// - Address mismatch logged only when config bit 30 is set.
// - Config bit 31 set skips the size check for status bits 0 and 1.
// - Failed 36-bit address captured: upper nibble and lower word, valid-qualified.
// - Mismatch or illegal command is a failure; sniffer matches also captured.
// - Only singles, lines and bursts legal; posting off allows singles only.
// - A write to qualifier register clears it and both address registers, unless a capture loads them in the same cycle.
// - With hold lock set, capture updates only while valid is 0 or in a cycle that writes the qualifier register.
// - Qualifier register holds valid, lock error, id, width, type, rnw, size, lanes.
// - Misc status bits clear individually on write of 1.
// - Interrupt 11 from config/illegal/mismatch bits, 15 from queue bits.
// - Status bit 0 set when posting off and any size other than single arrives with check enabled.
// - Status bit 1 set for sizes outside 0-3 and A-C when check enabled.
// - Sticky queue overflow and underflow flags sit in status bits 18-31.
// - One master interrupt bit per master in bits 28-31, two set sources.
// - Misc control write-only bits read 0; bit 0 shows the port width.
// - Writing 1 to control bits 25-31 resets seven queues.
module slave_port_cfg_error_logging #(
    parameter logic WIDE_PORT = 1'b1
) (
    input  wire logic        clk,                        // 200 MHz clock
    input  wire logic        resetn,                     // synchronous reset, low
    input  wire logic [9:0]  reg_index,                  // register index
    input  wire logic        reg_read,                   // read strobe
    input  wire logic        reg_write,                  // write strobe
    input  wire logic [0:31] reg_wdata,                  // write data
    output logic      [0:31] reg_rdata,                  // read data
    output logic             reg_ack,                    // access done pulse
    input  wire logic        cmd_valid,                  // command pulse
    input  wire logic [35:0] cmd_addr,                   // command address
    input  wire logic [3:0]  cmd_size,                   // size code
    input  wire logic        cmd_read_not_write,         // 1 is read
    input  wire logic [1:0]  cmd_master_id,              // master id
    input  wire logic [1:0]  cmd_master_width_code,      // master width
    input  wire logic [2:0]  cmd_type,                   // transfer type
    input  wire logic [15:0] cmd_byte_lane_mask,         // byte enables
    input  wire logic        cmd_lock_request,           // locked request
    input  wire logic        cmd_address_mismatch,       // address bus mismatch
    input  wire logic        master_lock_error,          // lock error level
    input  wire logic        sniff_match,                // sniffer hit pulse
    input  wire logic [13:0] queue_event,                // queue flag pulses
    input  wire logic [3:0]  slave_irq_request,          // slave irq pulses
    input  wire logic [3:0]  master_write_error,         // write error pulses
    output logic      [2:0]  write_memctl_burst_threshold,     // threshold field
    output logic      [2:0]  write_masterport_burst_threshold, // threshold field
    output logic             locked_transfer_enable,     // lock enable
    output logic             read_addr_pipeline_enable,  // read pipelining
    output logic             write_addr_pipeline_enable, // write pipelining
    output logic             write_posting_enable,       // write posting
    output logic             cmd_accept,                 // legal command pulse
    output logic             cmd_reject,                 // illegal command pulse
    output logic             lock_granted,               // locked command pulse
    output logic             config_error_irq,           // interrupt bit 11 level
    output logic             queue_error_irq,            // interrupt bit 15 level
    output logic      [6:0]  queue_reset                 // queue reset pulses
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [0:31] port_config;
    logic [0:31] fail_addr_upper;
    logic [0:31] fail_addr_lower;
    logic [0:31] fail_qualifiers;
    logic [0:31] misc_status;
    logic [0:31] master_irq_status;
    logic [0:31] next_misc_status;
    logic [0:31] next_master_irq_status;

    logic size_legal;
    logic multi_beat;
    logic check_on;
    logic posting_err;
    logic illegal_cmd;
    logic mismatch_err;
    logic capture;
    logic wr_config;
    logic wr_qual;

    assign wr_config = reg_write && (reg_index == slave_port_regs_pkg::IDX_PORT_CONFIG);
    assign wr_qual   = reg_write && (reg_index == slave_port_regs_pkg::IDX_FAIL_QUALIFIERS);

    // ------------------------------------------------------------------
    // Command checking
    // ------------------------------------------------------------------
    // legal command set
    assign size_legal = (cmd_size <= slave_port_regs_pkg::SIZE_LINE_LAST) ||
                        ((cmd_size >= slave_port_regs_pkg::SIZE_BURST_LO) &&
                         (cmd_size <= slave_port_regs_pkg::SIZE_BURST_HI));
    assign multi_beat = (cmd_size != slave_port_regs_pkg::SIZE_SINGLE);
    assign check_on   = !port_config[slave_port_regs_pkg::CFG_SIZE_CHECK_OFF];
    assign posting_err  = cmd_valid && check_on && multi_beat &&
                          !port_config[slave_port_regs_pkg::CFG_WRITE_POST];
    assign illegal_cmd  = cmd_valid && check_on && !size_legal;
    assign mismatch_err = cmd_valid && cmd_address_mismatch &&
                          port_config[slave_port_regs_pkg::CFG_MISMATCH_LOG];
    assign capture = posting_err || illegal_cmd || mismatch_err || sniff_match;

    // ------------------------------------------------------------------
    // Port configuration
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            port_config <= slave_port_regs_pkg::PORT_CONFIG_RESET;
        end else if (wr_config) begin
            port_config <= reg_wdata;
            port_config[slave_port_regs_pkg::CFG_WRITE_PIPE] <=
                reg_wdata[slave_port_regs_pkg::CFG_WRITE_PIPE] &&
                reg_wdata[slave_port_regs_pkg::CFG_WRITE_POST];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            write_memctl_burst_threshold     <= 3'h3;
            write_masterport_burst_threshold <= 3'h3;
            locked_transfer_enable           <= 1'b1;
            read_addr_pipeline_enable        <= 1'b1;
            write_addr_pipeline_enable       <= 1'b0;
            write_posting_enable             <= 1'b1;
        end else begin
            write_memctl_burst_threshold <=
                port_config[slave_port_regs_pkg::CFG_WR_MEMCTL_THR_LSB-2 +: 3];
            write_masterport_burst_threshold <=
                port_config[slave_port_regs_pkg::CFG_WR_MASTER_THR_LSB-2 +: 3];
            locked_transfer_enable <= port_config[slave_port_regs_pkg::CFG_LOCKED_XFER];
            read_addr_pipeline_enable <= port_config[slave_port_regs_pkg::CFG_READ_PIPE];
            write_addr_pipeline_enable <= port_config[slave_port_regs_pkg::CFG_WRITE_PIPE];
            write_posting_enable <= port_config[slave_port_regs_pkg::CFG_WRITE_POST];
        end
    end

    // ------------------------------------------------------------------
    // Command verdict
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cmd_accept   <= 1'b0;
            cmd_reject   <= 1'b0;
            lock_granted <= 1'b0;
        end else begin
            cmd_accept   <= cmd_valid && !posting_err && !illegal_cmd;
            cmd_reject   <= posting_err || illegal_cmd;
            lock_granted <= cmd_valid && cmd_lock_request && !posting_err && !illegal_cmd &&
                            port_config[slave_port_regs_pkg::CFG_LOCKED_XFER];
        end
    end

    // ------------------------------------------------------------------
    // Failed transaction capture
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            fail_addr_upper <= slave_port_regs_pkg::ZERO_WORD;
            fail_addr_lower <= slave_port_regs_pkg::ZERO_WORD;
            fail_qualifiers <= slave_port_regs_pkg::ZERO_WORD;
        end else if (capture && (!port_config[slave_port_regs_pkg::CFG_CAPTURE_HOLD_LOCK] ||
                                 !fail_qualifiers[0] || wr_qual)) begin
            fail_addr_upper <= {28'h000_0000, cmd_addr[35:32]};
            fail_addr_lower <= cmd_addr[31:0];
            fail_qualifiers <= {1'b1, master_lock_error, 2'b00, cmd_master_id,
                                cmd_master_width_code, cmd_type, cmd_read_not_write,
                                cmd_size, cmd_byte_lane_mask};
        end else if (wr_qual) begin
            fail_addr_upper <= slave_port_regs_pkg::ZERO_WORD;
            fail_addr_lower <= slave_port_regs_pkg::ZERO_WORD;
            fail_qualifiers <= slave_port_regs_pkg::ZERO_WORD;
        end
    end

    // ------------------------------------------------------------------
    // Sticky status; a new event wins over a clear in the same cycle
    // ------------------------------------------------------------------
    always_comb begin
        next_misc_status       = misc_status;
        next_master_irq_status = master_irq_status;
        if (reg_write && (reg_index == slave_port_regs_pkg::IDX_MISC_STATUS)) begin
            next_misc_status = misc_status & ~reg_wdata;
        end
        if (reg_write && (reg_index == slave_port_regs_pkg::IDX_MASTER_IRQ_STATUS)) begin
            next_master_irq_status = master_irq_status & ~reg_wdata;
        end
        next_misc_status[slave_port_regs_pkg::ST_POSTING_CFG_ERR] =
            next_misc_status[slave_port_regs_pkg::ST_POSTING_CFG_ERR] || posting_err;
        next_misc_status[slave_port_regs_pkg::ST_ILLEGAL_CMD] =
            next_misc_status[slave_port_regs_pkg::ST_ILLEGAL_CMD] || illegal_cmd;
        next_misc_status[slave_port_regs_pkg::ST_ADDR_MISMATCH] =
            next_misc_status[slave_port_regs_pkg::ST_ADDR_MISMATCH] || mismatch_err;
        for (int i = 0; i < slave_port_regs_pkg::QUEUE_FLAG_COUNT; i++) begin
            next_misc_status[slave_port_regs_pkg::ST_QUEUE_FIRST + i] =
                next_misc_status[slave_port_regs_pkg::ST_QUEUE_FIRST + i] || queue_event[i];
        end
        for (int m = 0; m < slave_port_regs_pkg::MASTER_COUNT; m++) begin
            next_master_irq_status[slave_port_regs_pkg::MASTER_INTERRUPT_REQUEST_FIRST + m] =
                next_master_irq_status[slave_port_regs_pkg::MASTER_INTERRUPT_REQUEST_FIRST + m] ||
                slave_irq_request[m] ||
                (master_write_error[m] && port_config[slave_port_regs_pkg::CFG_WRITE_POST]);
        end
        next_misc_status[3:17]        = 15'h0000;
        next_master_irq_status[0:27]  = 28'h000_0000;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            misc_status       <= slave_port_regs_pkg::ZERO_WORD;
            master_irq_status <= slave_port_regs_pkg::ZERO_WORD;
        end else begin
            misc_status       <= next_misc_status;
            master_irq_status <= next_master_irq_status;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            config_error_irq <= 1'b0;
            queue_error_irq  <= 1'b0;
        end else begin
            config_error_irq <= |misc_status[0:2];
            queue_error_irq  <= |misc_status[18:31];
        end
    end

    // ------------------------------------------------------------------
    // Queue resets
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            queue_reset <= 7'h00;
        end else if (reg_write && (reg_index == slave_port_regs_pkg::IDX_MISC_CONTROL)) begin
            queue_reset <= reg_wdata[slave_port_regs_pkg::QRESET_FIRST +: 7];
        end else begin
            queue_reset <= 7'h00;
        end
    end

    // ------------------------------------------------------------------
    // Register read port, answered one cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= slave_port_regs_pkg::ZERO_WORD;
            reg_ack   <= 1'b0;
        end else begin
            reg_ack   <= reg_read || reg_write;
            reg_rdata <= slave_port_regs_pkg::ZERO_WORD;
            if (reg_read) begin
                case (reg_index)
                    slave_port_regs_pkg::IDX_PORT_CONFIG:       reg_rdata <= port_config;
                    slave_port_regs_pkg::IDX_FAIL_ADDR_UPPER:   reg_rdata <= fail_addr_upper;
                    slave_port_regs_pkg::IDX_FAIL_ADDR_LOWER:   reg_rdata <= fail_addr_lower;
                    slave_port_regs_pkg::IDX_FAIL_QUALIFIERS:   reg_rdata <= fail_qualifiers;
                    slave_port_regs_pkg::IDX_MISC_STATUS:       reg_rdata <= misc_status;
                    slave_port_regs_pkg::IDX_MASTER_IRQ_STATUS: reg_rdata <= master_irq_status;
                    slave_port_regs_pkg::IDX_MISC_CONTROL: begin
                        reg_rdata[slave_port_regs_pkg::CTL_WIDE_PORT] <= WIDE_PORT;
                    end
                    default: reg_rdata <= slave_port_regs_pkg::ZERO_WORD;
                endcase
            end
        end
    end

endmodule

// [test/fabric_master.sv]
// Fabric bus master model that issues commands toward the slave port.
`timescale 1ns/1ps
module fabric_master (
    input  wire logic   clk,                    // clock
    output logic        valid, read_not_write, lock, mism, // command pulse and flags
    output logic [35:0] addr,                   // command address
    output logic [3:0]  size,                   // size code
    output logic [1:0]  id, width,              // master id and width
    output logic [15:0] lanes                   // byte enables
);
    initial {valid, read_not_write, lock, mism, addr, size, id, width, lanes} = '0;
    // Qualifiers except id and width turn to their inverse between commands so stale values never pass.
    task automatic send(input logic [35:0] a, input logic [3:0] s, input logic [2:0] f);
        @(posedge clk);
        valid <= 1'b1;
        addr <= a;
        size <= s;
        {read_not_write, lock, mism} <= f;
        {width, id} <= a[3:0];
        lanes <= a[15:0];
        @(posedge clk);
        valid <= 1'b0;
        addr <= ~a;
        size <= ~s;
        {read_not_write, lock, mism} <= ~f;
        lanes <= ~a[15:0];
    endtask
endmodule

// [test/slave_port_cfg_error_logging_assertions.sv]
// Concurrent checks on the slave port register block.
`timescale 1ns/1ps
module slave_port_checks #(parameter logic WIDE_PORT = 1'b1) (
    input wire logic        clk, resetn, reg_read, reg_write, reg_ack, // clock, reset, port
    input wire logic [9:0]  reg_index,                                 // register index
    input wire logic [0:31] reg_wdata, reg_rdata,                      // data words
    input wire logic        cmd_valid, cmd_lock_request, cmd_accept,   // command side
    input wire logic        cmd_reject, lock_granted, queue_error_irq, // command answers
    input wire logic        write_posting_enable, write_addr_pipeline_enable, // copies
    input wire logic [13:0] queue_event,                               // queue pulses
    input wire logic [6:0]  queue_reset                                // reset pulses
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ack_follows_req_a: assert property ((reg_read || reg_write) |=> reg_ack)
        else $error("no acknowledge after access");
    rdata_idle_a: assert property (!reg_ack |-> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside acknowledge");
    write_addr_pipeline_enable_forced_a: assert property (!write_posting_enable |-> !write_addr_pipeline_enable)
        else $error("write pipelining on without posting");
    reject_cause_a: assert property (cmd_reject |-> $past(cmd_valid))
        else $error("reject without command");
    verdict_once_a: assert property ((cmd_accept || cmd_reject) |->
        $past(cmd_valid) && !(cmd_accept && cmd_reject)) else $error("bad command verdict");
    lock_grant_a: assert property (lock_granted |-> $past(cmd_valid && cmd_lock_request))
        else $error("lock granted without locked request");
    queue_irq_a: assert property (queue_event != 14'h0000 |-> ##2 queue_error_irq)
        else $error("queue interrupt missing");
    ctl_read_a: assert property (reg_read && reg_index == 10'h04c |=>
        reg_rdata == {WIDE_PORT, 31'h0000_0000}) else $error("control readback wrong");
    qreset_pulse_a: assert property (reg_write && reg_index == 10'h04c |=>
        queue_reset == $past(reg_wdata[25:31])) else $error("queue reset pulse wrong");
    qreset_quiet_a: assert property (!(reg_write && reg_index == 10'h04c) |=>
        queue_reset == 7'h00) else $error("spurious queue reset");
    cover property (cmd_reject);
    cover property (lock_granted);
    cover property (queue_reset != 7'h00);
endmodule
bind slave_port_cfg_error_logging slave_port_checks #(.WIDE_PORT(WIDE_PORT)) u_checks (
    .clk(clk), .resetn(resetn), .reg_read(reg_read), .reg_write(reg_write), .reg_ack(reg_ack),
    .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cmd_valid(cmd_valid), .cmd_lock_request(cmd_lock_request), .cmd_accept(cmd_accept),
    .cmd_reject(cmd_reject), .lock_granted(lock_granted), .queue_error_irq(queue_error_irq),
    .write_posting_enable(write_posting_enable), .queue_event(queue_event),
    .write_addr_pipeline_enable(write_addr_pipeline_enable), .queue_reset(queue_reset));

// [test/tb_top.sv]
// Self-checking bench for the slave port register block.
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0, resetn = 1'b0, reg_read = 1'b0, reg_write = 1'b0, lock_err = 1'b0;
    logic [9:0]  reg_index = 10'h000;
    logic [0:31] reg_wdata = 32'h0000_0000, reg_rdata, rd;
    logic [13:0] q_ev = 14'h0000;
    logic [3:0]  s_irq = 4'h0, m_err = 4'h0, c_size;
    logic        reg_ack, c_valid, c_rnw, c_lock, c_mism, ok, rej, grant, cfg_irq, q_irq;
    logic        lte, rpe, wpe, wpo;
    logic [35:0] c_addr;
    logic [1:0]  c_id, c_width;
    logic [15:0] c_lanes;
    logic [2:0]  thr_m, thr_p;
    logic [6:0]  q_rst;
    int          bad_count = 0, checks_done = 0, cycles = 0;
    always #2.5 clk = ~clk;
    fabric_master u_src (.clk(clk), .valid(c_valid), .read_not_write(c_rnw), .lock(c_lock), .mism(c_mism),
        .addr(c_addr), .size(c_size), .id(c_id), .width(c_width), .lanes(c_lanes));
    slave_port_cfg_error_logging u_dut (
        .clk(clk), .resetn(resetn), .reg_index(reg_index), .reg_read(reg_read),
        .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .cmd_valid(c_valid), .cmd_addr(c_addr), .cmd_size(c_size), .cmd_read_not_write(c_rnw),
        .cmd_master_id(c_id), .cmd_master_width_code(c_width), .cmd_type(3'h0),
        .cmd_byte_lane_mask(c_lanes), .cmd_lock_request(c_lock), .cmd_address_mismatch(c_mism),
        .master_lock_error(lock_err), .sniff_match(1'b0), .queue_event(q_ev),
        .slave_irq_request(s_irq), .master_write_error(m_err),
        .write_memctl_burst_threshold(thr_m), .write_masterport_burst_threshold(thr_p),
        .locked_transfer_enable(lte), .read_addr_pipeline_enable(rpe),
        .write_addr_pipeline_enable(wpe), .write_posting_enable(wpo), .cmd_accept(ok),
        .cmd_reject(rej), .lock_granted(grant), .config_error_irq(cfg_irq),
        .queue_error_irq(q_irq), .queue_reset(q_rst));
    task automatic chk(input logic [0:31] seen, input logic [0:31] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic access(input logic w, input logic [9:0] idx, input logic [0:31] d);
        @(posedge clk);
        reg_index <= idx;
        reg_write <= w;
        reg_read <= !w;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        #1;
        chk(reg_ack, 1'b1);
        rd = reg_rdata;
    endtask
    task automatic rchk(input logic [9:0] idx, input logic [0:31] exp);
        access(1'b0, idx, 32'h0000_0000);
        chk(rd, exp);
    endtask
    function automatic logic [0:31] cfg(input logic [2:0] t, input logic [3:0] b,
                                        input logic [2:0] m);
        logic [0:31] v;
        v = 32'h8033_336c;
        v[17:19] = t;
        v[21:23] = t;
        v[25:28] = b;
        {v[0], v[30], v[31]} = m;
        return v;
    endfunction
    task automatic send(input logic [35:0] a, input logic [3:0] s, input logic [2:0] f);
        u_src.send(a, s, f);
        #1;
    endtask
    task automatic t_reset;
        rchk(10'h044, 32'h8033_336c);
        for (int i = 6; i < 12; i++) rchk(10'h040 + i[9:0], 32'h0000_0000);
        rchk(10'h04c, 32'h8000_0000);
        rchk(10'h045, 32'h0000_0000);
        chk({thr_m, thr_p, lte, rpe, wpe, wpo}, 10'h1bd);
    endtask
    task automatic t_config;
        for (int t = 0; t < 5; t++) begin
            access(1'b1, 10'h044, cfg(t[2:0], 4'b0111, 3'b100));
            rchk(10'h044, cfg(t[2:0], 4'b0111, 3'b100));
            chk({thr_m, thr_p, lte, rpe, wpe, wpo}, {t[2:0], t[2:0], 4'b0111});
        end
        send(36'h0_0000_0000, 4'h0, 3'b010);
        chk(grant, 1'b0);
        access(1'b1, 10'h044, cfg(3'b011, 4'b0010, 3'b100));
        rchk(10'h044, cfg(3'b011, 4'b0000, 3'b100));
        chk({lte, rpe, wpe, wpo}, 4'b0000);
        access(1'b1, 10'h044, 32'h8033_336c);
        send(36'h0_0000_0000, 4'h0, 3'b010);
        chk(grant, 1'b1);
    endtask
    task automatic t_capture;
        @(posedge clk);
        lock_err <= 1'b1;
        send(36'h9_1234_5679, 4'h5, 3'b100);
        chk(rej, 1'b1);
        send(36'h0_0000_0004, 4'hd, 3'b000);
        rchk(10'h046, 32'h0000_0009);
        rchk(10'h047, 32'h1234_5679);
        rchk(10'h048, 32'hc615_5679);
        rchk(10'h049, 32'h4000_0000);
        chk(cfg_irq, 1'b1);
        access(1'b1, 10'h048, 32'hffff_ffff);
        for (int i = 6; i < 9; i++) rchk(10'h040 + i[9:0], 32'h0000_0000);
        access(1'b1, 10'h044, 32'h0033_336c);
        @(posedge clk) lock_err <= 1'b0;
        send(36'h1_0000_0002, 4'h4, 3'b000);
        send(36'h2_aaaa_bbbc, 4'hf, 3'b000);
        rchk(10'h046, 32'h0000_0002);
        rchk(10'h047, 32'haaaa_bbbc);
        access(1'b1, 10'h049, 32'h4000_0000);
        rchk(10'h049, 32'h0000_0000);
        chk(cfg_irq, 1'b0);
    endtask
    task automatic t_post;
        access(1'b1, 10'h044, cfg(3'b011, 4'b1100, 3'b100));
        send(36'h0_0000_0000, 4'h0, 3'b000);
        chk(ok, 1'b1);
        send(36'h0_0000_0000, 4'h2, 3'b000);
        rchk(10'h049, 32'h8000_0000);
        chk(cfg_irq, 1'b1);
        access(1'b1, 10'h049, 32'h8000_0000);
        access(1'b1, 10'h044, cfg(3'b011, 4'b1100, 3'b101));
        send(36'h0_0000_0000, 4'h5, 3'b000);
        send(36'h0_0000_0000, 4'h2, 3'b001);
        rchk(10'h049, 32'h0000_0000);
        access(1'b1, 10'h044, cfg(3'b011, 4'b1101, 3'b110));
        send(36'h0_0000_0000, 4'h0, 3'b001);
        rchk(10'h049, 32'h2000_0000);
        access(1'b1, 10'h049, 32'hffff_ffff);
        access(1'b1, 10'h044, 32'h8033_336c);
    endtask
    task automatic t_status;
        @(posedge clk);
        q_ev <= 14'h3fff;
        s_irq <= 4'h5;
        m_err <= 4'ha;
        @(posedge clk);
        q_ev <= 14'h0000;
        s_irq <= 4'h0;
        m_err <= 4'h0;
        rchk(10'h049, 32'h0000_3fff);
        chk(q_irq, 1'b1);
        rchk(10'h04a, 32'h0000_000f);
        access(1'b1, 10'h049, 32'h0000_2aaa);
        rchk(10'h049, 32'h0000_1555);
        access(1'b1, 10'h04a, 32'h0000_0005);
        rchk(10'h04a, 32'h0000_000a);
        access(1'b1, 10'h049, 32'hffff_ffff);
        rchk(10'h049, 32'h0000_0000);
        chk(q_irq, 1'b0);
    endtask
    task automatic t_qreset;
        for (int k = 0; k < 7; k++) begin
            access(1'b1, 10'h04c, 32'h0000_0040 >> k);
            chk(q_rst, 7'h40 >> k);
        end
        rchk(10'h04c, 32'h8000_0000);
    endtask
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_config();
        t_capture();
        t_post();
        t_status();
        t_qreset();
        end_sim();
    end
endmodule
